// *** verilog/tx_port_status_interrupt_regs.sv ***
`timescale 1ns/10ps
`default_nettype none

module tx_port_status_interrupt_regs
  import tx_port_pkg::*;
#(
  parameter int FRAME_CYC = FRAME_CYCLES
)(
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // wishbone slave
  input  wire logic       cyc_i,
  input  wire logic       stb_i,
  input  wire logic       we_i,
  input  wire logic [3:0] sel_i,
  input  wire logic [10:2] adr_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // event sources
  input  wire tx_events_s  events_i,
  input  wire logic [6:0]  fifo_level_i,
  input  wire logic        fifo_full_i,
  input  wire logic        tx_line_clock_in_i,
  // bit stream
  input  wire logic        line_data_i,
  input  wire logic        sys_data_i,
  input  wire logic        pattern_data_i,
  input  wire logic [2:0]  chan_bit_i,
  input  wire logic        fbit_slot_i,
  output logic             tx_line_data_o,
  output logic             rx_system_serial_out_o,
  output logic             pattern_take_o,
  // synchronizer control
  output logic             sync_run_o,
  output logic             crc4_search_o,
  output logic             auto_resync_o,
  output logic             resync_start_o,
  // pins
  output logic             tx_clock_loss_o,
  output logic             irq_out_n_o
);

  // ****************************************************
  // registers and bus
  // ****************************************************
  logic [7:0] tp_ctrl, tp_supp, sync_ctl, mode, wm_sel;
  logic [7:0] mask1, mask2, mask3, ls1, ls2, ls3;
  logic [7:0] set1, set2, set3, rd;
  logic [2:0] info;
  logic       wr, resync_prev;

  assign wr = cyc_i && stb_i && we_i && ack_o && sel_i[0];

  function automatic logic hit(input logic [8:0] idx);
    return wr && (adr_i == idx);
  endfunction : hit

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_o <= 1'b0;
    else
      ack_o <= cyc_i && stb_i && !ack_o;
  end

  always_comb
  begin
    case (adr_i)
      IDX_WM_SEL:  rd = wm_sel;
      IDX_TP_CTRL: rd = tp_ctrl;
      IDX_TP_SUPP: rd = tp_supp;
      IDX_SYNC:    rd = sync_ctl;
      IDX_LS1:     rd = ls1;
      IDX_LS2:     rd = ls2;
      IDX_LS3:     rd = {6'h00, events_i.sync_hunting, ls3[SYNC_LOSS]};
      IDX_INFO:    rd = {5'h00, info};
      IDX_MASK1:   rd = mask1;
      IDX_MASK2:   rd = mask2;
      IDX_MASK3:   rd = mask3;
      IDX_MODE:    rd = mode;
      default:     rd = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      dat_o <= 32'h00000000;
    else if (cyc_i && stb_i && !ack_o)
      dat_o <= {24'h000000, rd};
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tp_ctrl  <= REG_RESET;
      tp_supp  <= REG_RESET;
      sync_ctl <= REG_RESET;
      mode     <= REG_RESET;
      wm_sel   <= REG_RESET;
      mask1    <= REG_RESET;
      mask2    <= REG_RESET;
      mask3    <= REG_RESET;
    end
    else
    begin
      if (hit(IDX_TP_CTRL)) tp_ctrl  <= {5'h00, dat_i[2:0]};
      if (hit(IDX_TP_SUPP)) tp_supp  <= dat_i[7:0];
      if (hit(IDX_SYNC))    sync_ctl <= {4'h0, dat_i[3:0]};
      if (hit(IDX_MODE))    mode     <= {4'h0, dat_i[3:0]};
      if (hit(IDX_WM_SEL))  wm_sel   <= {6'h00, dat_i[1:0]};
      if (hit(IDX_MASK1))   mask1    <= dat_i[7:0];
      if (hit(IDX_MASK2))   mask2    <= {3'h0, dat_i[4:0]};
      if (hit(IDX_MASK3))   mask3    <= {7'h00, dat_i[0]};
    end
  end

  // ****************************************************
  // test pattern routing
  // ****************************************************
  logic use_pat;

  always_comb
  begin
    if (!tp_ctrl[TP_EN])
      use_pat = 1'b0;
    else if (fbit_slot_i)
      use_pat = tp_ctrl[TP_UNFR];
    else
      use_pat = !tp_supp[chan_bit_i];
  end

  assign pattern_take_o = use_pat;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tx_line_data_o         <= 1'b0;
      rx_system_serial_out_o <= 1'b0;
    end
    else
    begin
      tx_line_data_o <= (use_pat && !tp_ctrl[TP_DIR]) ?
                        pattern_data_i : line_data_i;
      rx_system_serial_out_o <= (use_pat && tp_ctrl[TP_DIR]) ?
                                pattern_data_i : sys_data_i;
    end
  end

  // ****************************************************
  // synchronizer control
  // ****************************************************
  assign sync_run_o    = sync_ctl[SY_EN];
  assign crc4_search_o = sync_ctl[SY_EN] && mode[MD_E1] &&
                         sync_ctl[SY_CRC4];
  assign auto_resync_o = sync_ctl[SY_EN] && !sync_ctl[SY_NOAUTO];

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      resync_prev    <= 1'b0;
      resync_start_o <= 1'b0;
    end
    else
    begin
      resync_prev    <= sync_ctl[SY_RESYNC];
      resync_start_o <= sync_ctl[SY_RESYNC] && !resync_prev;
    end
  end

  // ****************************************************
  // frame timing
  // ****************************************************
  logic [15:0] cyc_cnt;
  logic [7:0]  frm_cnt;
  logic        frame_tick;

  function automatic logic boundary(input logic [7:0] cnt, input int len);
    return (32'(cnt) % len) == (len - 1);
  endfunction : boundary

  assign frame_tick = (cyc_cnt == 16'(FRAME_CYC - 1));

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cyc_cnt <= 16'h0000;
    else
      cyc_cnt <= frame_tick ? 16'h0000 : cyc_cnt + 16'h0001;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      frm_cnt <= 8'h00;
    else if (frame_tick)
      frm_cnt <= (frm_cnt == 8'(FRAME_WRAP - 1)) ? 8'h00 : frm_cnt + 8'h01;
  end

  logic mf_hit, align_hit, slc_hit;
  int   mf_len;

  always_comb
  begin
    if (mode[MD_E1])
      mf_len = MF_E1_US / FRAME_US;
    else if (mode[MD_ESF])
      mf_len = MF_ESF_US / FRAME_US;
    else
      mf_len = MF_D4_US / FRAME_US;
  end

  assign mf_hit    = frame_tick && boundary(frm_cnt, mf_len);
  assign align_hit = frame_tick && mode[MD_E1] &&
                     boundary(frm_cnt, ALIGN_US / FRAME_US);
  assign slc_hit   = frame_tick && !mode[MD_E1] && mode[MD_SLC_EN] &&
                     boundary(frm_cnt, SLC_FRAMES);

  // ****************************************************
  // line clock watchdog
  // ****************************************************
  logic       lc_meta, lc_sync, lc_prev, loss_now, loss_prev;
  logic [7:0] idle_cnt;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      lc_meta <= 1'b0;
      lc_sync <= 1'b0;
      lc_prev <= 1'b0;
    end
    else
    begin
      lc_meta <= tx_line_clock_in_i;
      lc_sync <= lc_meta;
      lc_prev <= lc_sync;
    end
  end

  // saturates so a dead clock keeps the condition up indefinitely
  always_ff @(posedge clk_i)
  begin
    if (rst_i || lc_sync != lc_prev)
      idle_cnt <= 8'h00;
    else if (!loss_now)
      idle_cnt <= idle_cnt + 8'h01;
  end

  assign loss_now = (idle_cnt >= 8'(LOSS_CYCLES));

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      loss_prev       <= 1'b0;
      tx_clock_loss_o <= 1'b0;
    end
    else
    begin
      loss_prev       <= loss_now;
      tx_clock_loss_o <= loss_now && mode[MD_PIN_EN];
    end
  end

  // ****************************************************
  // latched status
  // ****************************************************
  logic [6:0] wm_level;
  logic       below_now, below_prev, full_prev, hunt_prev;

  always_comb
  begin
    case (wm_sel[1:0])
      2'h0:    wm_level = WM_0;
      2'h1:    wm_level = WM_1;
      2'h2:    wm_level = WM_2;
      default: wm_level = WM_3;
    endcase
  end

  assign below_now = fifo_level_i < wm_level;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      below_prev <= 1'b0;
      full_prev  <= 1'b0;
      hunt_prev  <= 1'b0;
    end
    else
    begin
      below_prev <= below_now;
      full_prev  <= fifo_full_i;
      hunt_prev  <= events_i.sync_hunting;
    end
  end

  always_comb
  begin
    set1 = 8'h00;
    set1[ES_FULL]  = events_i.es_overfill;
    set1[ES_EMPTY] = events_i.es_underflow;
    set1[ES_SLIP]  = events_i.es_overfill || events_i.es_underflow;
    set1[SLC_MF]   = slc_hit;
    set1[ALIGN_F]  = align_hit;
    set1[MULTI_F]  = mf_hit;
    set1[CLK_CLR]  = loss_prev && !loss_now;
    set1[CLK_LOSS] = loss_now && !loss_prev;
    set2 = 8'h00;
    set2[DL_EMPTY] = events_i.datalink_shifted && !mode[MD_E1];
    set2[UNDERRUN] = events_i.fifo_underrun;
    set2[MSG_END]  = events_i.message_end;
    set2[BELOW_WM] = below_now && !below_prev;
    set2[NOT_FULL] = full_prev && !fifo_full_i;
    set3 = 8'h00;
    set3[SYNC_LOSS] = events_i.sync_hunting && !hunt_prev;
  end

  // a new event in the clearing cycle wins over the clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ls1 <= REG_RESET;
      ls2 <= REG_RESET;
      ls3 <= REG_RESET;
    end
    else
    begin
      ls1 <= (ls1 & ~(hit(IDX_LS1) ? dat_i[7:0] : 8'h00)) | set1;
      ls2 <= (ls2 & ~(hit(IDX_LS2) ? dat_i[7:0] : 8'h00)) | set2;
      ls3 <= (ls3 & ~(hit(IDX_LS3) ? dat_i[7:0] : 8'h00)) | set3;
    end
  end

  // ****************************************************
  // interrupt
  // ****************************************************
  assign info = {|(ls3 & mask3), |(ls2 & mask2), |(ls1 & mask1)};

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_out_n_o <= 1'b1;
    else
      irq_out_n_o <= !(|info);
  end

  // ****************************************************
  // checks
  // ****************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence resync_rise_s;
    !sync_ctl[SY_RESYNC] ##1 sync_ctl[SY_RESYNC];
  endsequence

  sequence overfill_s;
    events_i.es_overfill;
  endsequence

  resync_edge_a: assert property (resync_rise_s |=> resync_start_o)
    else $error("resync start missing after bit rise");
  resync_once_a: assert property (resync_start_o |=> !resync_start_o)
    else $error("resync start repeated while bit held");
  slip_set_a: assert property (overfill_s |=> ls1[ES_FULL] && ls1[ES_SLIP])
    else $error("overfill did not latch full and slip");
  empty_set_a: assert property (events_i.es_underflow |=>
                                ls1[ES_EMPTY] && ls1[ES_SLIP])
    else $error("underflow did not latch empty and slip");
  flag_clear_a: assert property (hit(IDX_LS2) && dat_i[MSG_END] &&
                                 !events_i.message_end |=> !ls2[MSG_END])
    else $error("write one did not clear flag");
  flag_hold_a: assert property (ls1[MULTI_F] && !hit(IDX_LS1) |=>
                                ls1[MULTI_F])
    else $error("latched flag dropped without write");
  irq_low_a: assert property ((ls1 & mask1) != 8'h00 |=> !irq_out_n_o)
    else $error("interrupt not asserted for pending flag");
  irq_high_a: assert property (info == 3'h0 |=> irq_out_n_o)
    else $error("interrupt held with nothing pending");
  route_sys_a: assert property (tp_ctrl[TP_EN] && tp_ctrl[TP_DIR] &&
                                !fbit_slot_i && !tp_supp[chan_bit_i] |=>
                                rx_system_serial_out_o == $past(pattern_data_i) &&
                                tx_line_data_o == $past(line_data_i))
    else $error("pattern not routed to receive path");
  port_off_a: assert property (!tp_ctrl[TP_EN] |-> !pattern_take_o)
    else $error("pattern taken while port disabled");
  pin_follow_a: assert property (mode[MD_PIN_EN] && loss_now ##1
                                 mode[MD_PIN_EN] |-> tx_clock_loss_o)
    else $error("clock loss pin not high during loss");
  wm_edge_a: assert property (!below_now ##1 below_now |=>
                              ls2[BELOW_WM])
    else $error("below watermark edge not latched");

endmodule : tx_port_status_interrupt_regs

`default_nettype wire

// *** verilog/tx_port_pkg.sv ***
package tx_port_pkg;
  // register indexes; byte address is four times the index
  localparam logic [8:0] IDX_WM_SEL  = 9'h187;
  localparam logic [8:0] IDX_TP_CTRL = 9'h18a;
  localparam logic [8:0] IDX_TP_SUPP = 9'h18b;
  localparam logic [8:0] IDX_SYNC    = 9'h18e;
  localparam logic [8:0] IDX_LS1     = 9'h190;
  localparam logic [8:0] IDX_LS2     = 9'h191;
  localparam logic [8:0] IDX_LS3     = 9'h192;
  localparam logic [8:0] IDX_INFO    = 9'h19f;
  localparam logic [8:0] IDX_MASK1   = 9'h1a0;
  localparam logic [8:0] IDX_MASK2   = 9'h1a1;
  localparam logic [8:0] IDX_MASK3   = 9'h1a2;
  localparam logic [8:0] IDX_MODE    = 9'h1f0;
  localparam logic [7:0] REG_RESET   = 8'h00;
  // field positions
  localparam int TP_DIR = 2, TP_UNFR = 1, TP_EN = 0;
  localparam int SY_CRC4 = 3, SY_EN = 2, SY_NOAUTO = 1, SY_RESYNC = 0;
  localparam int ES_FULL = 7, ES_EMPTY = 6, ES_SLIP = 5, SLC_MF = 4;
  localparam int ALIGN_F = 3, MULTI_F = 2, CLK_CLR = 1, CLK_LOSS = 0;
  localparam int DL_EMPTY = 4, UNDERRUN = 3, MSG_END = 2;
  localparam int BELOW_WM = 1, NOT_FULL = 0;
  localparam int HUNT = 1, SYNC_LOSS = 0;
  localparam int MD_E1 = 0, MD_ESF = 1, MD_SLC_EN = 2, MD_PIN_EN = 3;
  // timing
  localparam int CLK_PERIOD_NS  = 10;
  localparam int FRAME_US       = 125;
  localparam int FRAME_CYCLES   = FRAME_US * 1000 / CLK_PERIOD_NS;
  localparam int ALIGN_US       = 250;
  localparam int MF_D4_US       = 1500;
  localparam int MF_ESF_US      = 3000;
  localparam int MF_E1_US       = 2000;
  localparam int SLC_FRAMES     = 72;
  localparam int FRAME_WRAP     = 144;
  localparam int LINE_PERIOD_NS = 648;
  localparam int LOSS_NS        = 3 * LINE_PERIOD_NS;
  localparam int LOSS_CYCLES    = LOSS_NS / CLK_PERIOD_NS;
  localparam int FIFO_BYTES     = 64;
  localparam logic [6:0] WM_0 = 7'h04, WM_1 = 7'h10, WM_2 = 7'h20;
  localparam logic [6:0] WM_3 = 7'h30;

  typedef struct packed {
    logic es_overfill;
    logic es_underflow;
    logic datalink_shifted;
    logic fifo_underrun;
    logic message_end;
    logic sync_hunting;
  } tx_events_s;
endpackage : tx_port_pkg

// *** verification/line_side_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// line clock source
// ****************************************
module line_side_model
  import tx_port_pkg::*;
(
  // control
  input  wire logic run_i,
  // pins
  output logic      line_clk_o
);
  // a dead line holds its level, so a stopped clock stands still
  initial line_clk_o = 1'b0;
  always #(LINE_PERIOD_NS / 2) if (run_i) line_clk_o = ~line_clk_o;
endmodule : line_side_model
`default_nettype wire

// *** verification/tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import tx_port_pkg::*;
;
  // short frames keep the multiframe waits brief
  localparam int FC = 20;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        we = 1'b0;
  logic [3:0]  sel = 4'h0;
  logic [8:0]  adr = 9'h000;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic        ack;
  tx_events_s  ev = '0;
  logic [6:0]  lvl = 7'h28;
  logic        full = 1'b0;
  logic        run = 1'b1;
  wire         lclk;
  logic        ld = 1'b0, sd = 1'b0, pd = 1'b0, fb = 1'b0;
  logic [2:0]  cb = 3'h0;
  logic        txd, rxd, take, srun, crc, ares, rsp, pin, irq_n;
  int          seed = 32'hdc6e;
  int          bad_count = 0;
  int          total_checks = 0;
  int          pulses = 0;
  logic [15:0] notes[$];
  logic [8:0]  idx[12] = '{IDX_WM_SEL, IDX_TP_CTRL, IDX_TP_SUPP, IDX_SYNC,
    IDX_LS1, IDX_LS3, IDX_INFO, IDX_MASK1, IDX_MASK2, IDX_MASK3, IDX_MODE,
    9'h100};
  logic [6:0]  thr[4] = '{WM_0, WM_1, WM_2, WM_3};

  always #5 clk_i = ~clk_i;

  tx_port_status_interrupt_regs #(.FRAME_CYC(FC)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(cyc), .we_i(we),
    .sel_i(sel), .adr_i(adr), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
    .events_i(ev), .fifo_level_i(lvl), .fifo_full_i(full),
    .tx_line_clock_in_i(lclk), .line_data_i(ld), .sys_data_i(sd),
    .pattern_data_i(pd), .chan_bit_i(cb), .fbit_slot_i(fb),
    .tx_line_data_o(txd), .rx_system_serial_out_o(rxd),
    .pattern_take_o(take), .sync_run_o(srun), .crc4_search_o(crc),
    .auto_resync_o(ares), .resync_start_o(rsp), .tx_clock_loss_o(pin),
    .irq_out_n_o(irq_n));

  line_side_model partner (.run_i(run), .line_clk_o(lclk));

  // ****************************************
  // checking
  // ****************************************
  task automatic fail(input string what);
    bad_count++;
    $display("Error at %0t: %s", $time, what);
  endtask : fail

  task automatic check_bit(input logic got, input logic exp, input string s);
    total_checks++;
    if (got !== exp) fail(s);
  endtask : check_bit

  // upper read bits must always be zero
  task automatic check_read(input logic [31:0] got);
    logic [15:0] n;
    total_checks++;
    if (notes.size() == 0) fail("read with no note");
    else
    begin
      n = notes.pop_front();
      if ((got & {24'hffffff, n[7:0]}) !== {24'h0, n[15:8]}) fail("read");
    end
  endtask : check_read

  always @(posedge clk_i) if (ack === 1'b1 && we === 1'b0) check_read(rdat);
  always @(posedge clk_i) if (rsp === 1'b1) pulses++;

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : report_and_stop

  // ****************************************
  // stimulus
  // ****************************************
  task automatic wb(input logic w, input logic [8:0] a, input logic [7:0] d,
                    input logic [7:0] m);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    sel <= 4'h1;
    adr <= a;
    wdat <= {24'h0, d};
    if (!w) notes.push_back({d, m});
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    if (n >= 20) fail("no ack");
    cyc <= 1'b0;
    we <= 1'b0;
  endtask : wb

  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    wb(1'b1, a, d, 8'h00);
  endtask : wr

  task automatic rd(input logic [8:0] a, input logic [7:0] e,
                    input logic [7:0] m);
    wb(1'b0, a, e, m);
  endtask : rd

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick

  // the live hunting level is left alone
  task automatic pulse(input logic [5:0] p);
    @(posedge clk_i);
    ev[5:1] <= p[5:1];
    @(posedge clk_i);
    ev[5:1] <= 5'h00;
  endtask : pulse

  task automatic done(input string s);
    $display("test %s done", s);
  endtask : done

  initial
  begin
    #200000;
    fail("timeout");
    report_and_stop();
  end

  initial
  begin
    logic [31:0] r;
    logic [7:0]  ctl, sup;
    logic        use_p;
    tick(6);
    rst_i <= 1'b0;
    foreach (idx[i]) rd(idx[i], 8'h00, 8'hff);
    for (int k = 0; k < 3; k++)
    begin
      r = $random(seed);
      wr(IDX_TP_SUPP, r[7:0]);
      rd(IDX_TP_SUPP, r[7:0], 8'hff);
      wr(IDX_MASK1, r[15:8]);
      rd(IDX_MASK1, r[15:8], 8'hff);
    end
    wr(IDX_MASK1, 8'h00);
    wr(9'h100, 8'hff);
    rd(9'h100, 8'h00, 8'hff);
    done("registers");
    pulse(6'b100000);
    tick(3);
    check_bit(irq_n, 1'b1, "masked flag drove irq");
    rd(IDX_LS1, 8'ha0, 8'he0);
    wr(IDX_LS1, 8'h80);
    rd(IDX_LS1, 8'h20, 8'he0);
    pulse(6'b010000);
    rd(IDX_LS1, 8'h60, 8'he0);
    wr(IDX_MASK1, 8'h40);
    tick(3);
    check_bit(irq_n, 1'b0, "irq not raised");
    rd(IDX_INFO, 8'h01, 8'hff);
    wr(IDX_LS1, 8'h40);
    tick(3);
    check_bit(irq_n, 1'b1, "irq not released");
    rd(IDX_INFO, 8'h00, 8'hff);
    wr(IDX_MASK1, 8'h00);
    done("store and irq");
    for (int s = 0; s < 4; s++)
    begin
      wr(IDX_WM_SEL, 8'(s));
      lvl <= thr[s];
      wr(IDX_LS2, 8'hff);
      rd(IDX_LS2, 8'h00, 8'h02);
      lvl <= thr[s] - 7'h01;
      tick(3);
      rd(IDX_LS2, 8'h02, 8'h02);
    end
    full <= 1'b1;
    wr(IDX_LS2, 8'hff);
    full <= 1'b0;
    pulse(6'b001110);
    tick(2);
    rd(IDX_LS2, 8'h1d, 8'h1f);
    wr(IDX_MASK2, 8'h10);
    rd(IDX_INFO, 8'h02, 8'h07);
    wr(IDX_MASK2, 8'h00);
    ev.sync_hunting <= 1'b1;
    tick(3);
    rd(IDX_LS3, 8'h03, 8'h03);
    wr(IDX_MASK3, 8'h01);
    rd(IDX_INFO, 8'h04, 8'h07);
    wr(IDX_MASK3, 8'h00);
    wr(IDX_LS3, 8'h01);
    rd(IDX_LS3, 8'h02, 8'h03);
    ev.sync_hunting <= 1'b0;
    tick(3);
    rd(IDX_LS3, 8'h00, 8'h03);
    done("hdlc and sync status");
    wr(IDX_MODE, 8'h01);
    wr(IDX_SYNC, 8'h0e);
    tick(1);
    check_bit(srun, 1'b1, "sync run");
    check_bit(crc, 1'b1, "crc4 search");
    check_bit(ares, 1'b0, "auto resync");
    wr(IDX_SYNC, 8'h04);
    tick(1);
    check_bit(crc | ~ares, 1'b0, "auto resync on");
    wr(IDX_SYNC, 8'h00);
    tick(1);
    check_bit(srun | crc | ares, 1'b0, "sync controls off");
    pulses = 0;
    wr(IDX_SYNC, 8'h01);
    wr(IDX_SYNC, 8'h01);
    tick(3);
    check_bit(pulses == 1, 1'b1, "resync count");
    wr(IDX_SYNC, 8'h00);
    wr(IDX_SYNC, 8'h01);
    tick(3);
    check_bit(pulses == 2, 1'b1, "second resync");
    wr(IDX_LS1, 8'hff);
    tick(17 * FC);
    rd(IDX_LS1, 8'h0c, 8'h1c);
    wr(IDX_MODE, 8'h06);
    wr(IDX_LS1, 8'hff);
    tick(73 * FC);
    rd(IDX_LS1, 8'h14, 8'h1c);
    done("framing timers");
    wr(IDX_MODE, 8'h08);
    wr(IDX_LS1, 8'h03);
    rd(IDX_LS1, 8'h00, 8'h03);
    run <= 1'b0;
    tick(LOSS_CYCLES + 70);
    check_bit(pin, 1'b1, "loss pin");
    rd(IDX_LS1, 8'h01, 8'h03);
    wr(IDX_LS1, 8'h01);
    tick(2);
    check_bit(pin, 1'b1, "pin held after clear");
    run <= 1'b1;
    tick(100);
    check_bit(pin, 1'b0, "pin after recovery");
    rd(IDX_LS1, 8'h02, 8'h03);
    done("clock loss");
    for (int k = 0; k < 6; k++)
    begin
      r = $random(seed);
      ctl = r[7:0];
      sup = r[15:8];
      wr(IDX_TP_CTRL, {5'h00, ctl[2:0]});
      wr(IDX_TP_SUPP, sup);
      repeat (12)
      begin
        @(posedge clk_i);
        r = $random(seed);
        ld <= r[0];
        sd <= r[1];
        pd <= r[2];
        fb <= r[3] & r[4];
        cb <= r[7:5];
        @(posedge clk_i);
        #1;
        use_p = ctl[0] & (fb ? ctl[1] : !sup[cb]);
        check_bit(take, use_p, "pattern take");
        check_bit(txd, (use_p & !ctl[2]) ? pd : ld, "line data");
        check_bit(rxd, (use_p & ctl[2]) ? pd : sd, "system data");
      end
    end
    done("pattern port");
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
